// *** acs_host_model.sv ***
/*
  Host-side reader: captures serial words from the converter, in master mode
  on rising serial clock edges inside a frame, in slave mode with its own clock.
  Assumes all inputs are synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
  input  wire logic        clk_i,
  input  wire logic        frame_i,
  input  wire logic        sclk_i,
  input  wire logic        sdo_i,
  input  wire logic        go_i,
  output logic             ext_clk_o,
  output logic [15:0]      word_o,
  output logic             valid_o
);
  logic sclk_q = 1'b0;
  logic frame_q = 1'b0;
  initial begin
    ext_clk_o = 1'b0;
    word_o = 16'h0;
    valid_o = 1'b0;
  end
  // master capture, word ends when the frame drops
  always @(posedge clk_i) begin
    sclk_q <= sclk_i;
    frame_q <= frame_i;
    if (frame_i && sclk_i && !sclk_q) word_o <= {word_o[14:0], sdo_i};
    if (frame_q && !frame_i) valid_o <= 1'b1;
    else if (valid_o) valid_o <= 1'b0;
  end
  // slave read: clock stands low outside the transfer
  always @(posedge go_i) begin
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      word_o <= {word_o[14:0], sdo_i};
      ext_clk_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    @(posedge clk_i);
    valid_o <= 1'b1;
  end
endmodule
`default_nettype wire

// *** acs_pkg.sv ***
/*
  Shared constants and types for the conversion timing and serial port block.
  Assumes a 40 MHz system clock; all timing counts derive from CLK_NS.
*/
package acs_pkg;

  localparam int CLK_NS = 25;
  localparam int WORD_BITS = 16;

  // longest conversion time per speed mode, in ns
  localparam int CONV_MAX_NS_FAST = 750;
  localparam int CONV_MAX_NS_NORM = 1000;
  localparam int CONV_MAX_NS_LOWP = 1250;
  // head-room so a fastest-mode read after conversion fits its busy limit
  localparam int CONV_MARGIN_CYC = 6;
  localparam logic [7:0] CONV_CYC_FAST = 8'((CONV_MAX_NS_FAST / CLK_NS) - CONV_MARGIN_CYC);
  localparam logic [7:0] CONV_CYC_NORM = 8'((CONV_MAX_NS_NORM / CLK_NS) - CONV_MARGIN_CYC);
  localparam logic [7:0] CONV_CYC_LOWP = 8'((CONV_MAX_NS_LOWP / CLK_NS) - CONV_MARGIN_CYC);

  // least delay from end of conversion to busy low, rounded up
  localparam int EOC_BUSY_NS = 10;
  localparam logic [7:0] EOC_BUSY_CYC = 8'((EOC_BUSY_NS + CLK_NS - 1) / CLK_NS);

  // typical start-to-frame delay when reading during conversion, in ns
  localparam int FRAME_DLY_NS_FAST = 25;
  localparam int FRAME_DLY_NS_NORM = 275;
  localparam int FRAME_DLY_NS_LOWP = 525;
  localparam logic [7:0] FRAME_CYC_FAST = 8'(FRAME_DLY_NS_FAST / CLK_NS);
  localparam logic [7:0] FRAME_CYC_NORM = 8'(FRAME_DLY_NS_NORM / CLK_NS);
  localparam logic [7:0] FRAME_CYC_LOWP = 8'(FRAME_DLY_NS_LOWP / CLK_NS);

  // typical frame end to busy low delay
  localparam int FRAME_BUSY_NS = 25;
  localparam logic [7:0] FRAME_BUSY_CYC = 8'(FRAME_BUSY_NS / CLK_NS);

  // least internal serial clock period per divider setting, in ns
  localparam int SCLK_PER_NS_00 = 25;
  localparam int SCLK_PER_NS_01 = 50;
  localparam int SCLK_PER_NS_10 = 100;
  localparam int SCLK_PER_NS_11 = 200;
  localparam logic [2:0] SCLK_HALF_00 = 3'((SCLK_PER_NS_00 + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [2:0] SCLK_HALF_01 = 3'((SCLK_PER_NS_01 + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [2:0] SCLK_HALF_10 = 3'((SCLK_PER_NS_10 + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [2:0] SCLK_HALF_11 = 3'((SCLK_PER_NS_11 + 2 * CLK_NS - 1) / (2 * CLK_NS));

  typedef enum logic [1:0] {SPD_FAST, SPD_NORM, SPD_LOWP} acs_speed_e;

endpackage

// *** acs_ser_if.sv ***
/*
  Link between the conversion controller and its serialiser.
  Assumes both ends share one clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
interface acs_ser_if;
  logic        load;
  logic [15:0] word;
  logic        start;
  logic [2:0]  half;
  logic        ext_mode;
  logic        ext_clk;
  logic        serial_data_in;
  logic        active;
  logic        done;
  logic        sclk;
  logic        sdo;

  modport ctl (output load, word, start, half, ext_mode, ext_clk, serial_data_in,
               input active, done, sclk, sdo);
  modport shf (input load, word, start, half, ext_mode, ext_clk, serial_data_in,
               output active, done, sclk, sdo);
endinterface
`default_nettype wire

// *** acs_serializer.sv ***
/*
  Serial shifter: sends a 16-bit word msb first, with its own divided clock
  or clocked by an external clock sampled on the system clock.
  Assumes the controller issues load and start and watches done.
*/
`timescale 1ns/100ps
`default_nettype none
module acs_serializer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  acs_ser_if.shf   ser
);
  import acs_pkg::*;

  logic [15:0] shreg_reg;
  logic [4:0]  bits_reg;
  logic [2:0]  div_reg;
  logic        sclk_reg;
  logic        act_reg;
  logic        done_reg;
  logic        eprev_reg;

  wire tick     = (div_reg == ser.half - 3'h1);
  wire ext_fall = eprev_reg & ~ser.ext_clk;
  // data changes on the falling clock edge; the reader samples on the rising one
  wire shift_ev = act_reg & (ser.ext_mode ? ext_fall : (tick & sclk_reg));
  wire last     = shift_ev & (bits_reg == 5'(WORD_BITS - 1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg_reg <= 16'h0000;
      bits_reg  <= 5'h00;
      div_reg   <= 3'h0;
      sclk_reg  <= 1'b0;
      act_reg   <= 1'b0;
      done_reg  <= 1'b0;
      eprev_reg <= 1'b0;
    end else begin
      eprev_reg <= ser.ext_clk;
      done_reg  <= last;
      if (ser.load) begin
        shreg_reg <= ser.word;
      end else if (shift_ev) begin
        shreg_reg <= {shreg_reg[14:0], ser.serial_data_in};
      end
      if (ser.start) begin
        act_reg  <= 1'b1;
        bits_reg <= 5'h00;
        div_reg  <= 3'h0;
        sclk_reg <= 1'b0;
      end else if (act_reg) begin
        if (shift_ev) begin
          bits_reg <= bits_reg + 5'h01;
        end
        if (last) begin
          act_reg <= 1'b0;
        end
        if (!ser.ext_mode) begin
          div_reg <= tick ? 3'h0 : div_reg + 3'h1;
          if (tick) begin
            sclk_reg <= ~sclk_reg & ~last;
          end
        end
      end
    end
  end

  assign ser.active = act_reg;
  assign ser.done   = done_reg;
  assign ser.sclk   = sclk_reg;
  assign ser.sdo    = shreg_reg[15];
endmodule
`default_nettype wire

// *** acs_top.sv ***
/*
  Conversion cycle timing and result output ports: start detection, busy,
  parallel result, master or slave serial output with frame marker.
  Assumes all pins are synchronous to CLOCK_I; the converter core presents
  its result on RESULT_I by the end of the conversion count.
*/
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - conversion finishes within 0.75, 1 or 1.25 us per speed mode
// - busy high at most 0.75, 1 or 1.25 us outside master read after conversion
// - parallel data valid by conversion limit and 12 ns before busy falls
// - busy falls at least 10 ns after internal end of conversion
// - master read after conversion: serial clock period from the divider setting
// - master read after conversion: busy width bounded by divider and speed
// - master read after conversion: frame marker rises at end of conversion
// - master read during conversion: frame rises 25, 275 or 525 ns after start
// - master read after conversion: busy falls about 25 ns after frame marker falls
// - chip select low enables frame and clock outputs in master mode, serial data output in serial mode
// - chip select high releases frame, clock and data outputs
module acs_top (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        NRST_I,
  // conversion control and configuration pins
  input  wire logic        CONVERSION_START_N_I,
  input  wire logic        FAST_MODE_I,
  input  wire logic        LOW_POWER_MODE_I,
  input  wire logic        SERIAL_MODE_I,
  input  wire logic        SERIAL_MASTER_I,
  input  wire logic        READ_DURING_I,
  input  wire logic [1:0]  SERIAL_CLOCK_DIVIDER_I,
  input  wire logic        CS_N_I,
  // converter core result
  input  wire logic [15:0] RESULT_I,
  // external serial clock and daisy-chain input
  input  wire logic        SERIAL_CLK_I,
  input  wire logic        SERIAL_DATA_IN_I,
  // status and parallel port
  output logic             BUSY_O,
  output logic [15:0]      DATA_O,
  output logic             DATA_OE_N_O,
  // serial port
  output logic             FRAME_O,
  output logic             FRAME_OE_N_O,
  output logic             SERIAL_CLK_O,
  output logic             SERIAL_CLK_OE_N_O,
  output logic             SERIAL_DATA_OUT_O,
  output logic             SERIAL_DATA_OUT_OE_N_O
);
  import acs_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_CONV, S_TAIL, S_XFER, S_FEND} acs_state_e;

  function automatic acs_speed_e speed_of(input logic fast, input logic lowp);
    if (lowp) begin
      speed_of = SPD_LOWP;
    end else if (fast) begin
      speed_of = SPD_FAST;
    end else begin
      speed_of = SPD_NORM;
    end
  endfunction

  function automatic logic [7:0] pick3(input acs_speed_e s, input logic [7:0] f,
                                       input logic [7:0] n, input logic [7:0] l);
    case (s)
      SPD_FAST: pick3 = f;
      SPD_LOWP: pick3 = l;
      default:  pick3 = n;
    endcase
  endfunction

  logic        rs1_reg;
  logic        rs2_reg;
  wire         rst_n = rs2_reg;

  acs_state_e  state_reg;
  acs_state_e  state_next;
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;
  logic        busy_reg;
  logic        busy_next;
  logic        frame_reg;
  logic        frame_next;
  logic [15:0] result_reg;
  logic        sprev_reg;
  logic        data_oe_n_reg;
  logic        ms_oe_n_reg;
  logic        sdo_oe_n_reg;

  acs_ser_if ser ();

  acs_serializer u_ser (
    .clk_i   (CLOCK_I),
    .rst_n_i (rst_n),
    .ser     (ser)
  );

  wire acs_speed_e speed = speed_of(FAST_MODE_I, LOW_POWER_MODE_I);
  wire [7:0] conv_cyc    = pick3(speed, CONV_CYC_FAST, CONV_CYC_NORM, CONV_CYC_LOWP);
  wire [7:0] frame_cyc   = pick3(speed, FRAME_CYC_FAST, FRAME_CYC_NORM, FRAME_CYC_LOWP);
  wire start_fall        = sprev_reg & ~CONVERSION_START_N_I;
  wire master            = SERIAL_MODE_I & SERIAL_MASTER_I;
  wire master_after      = master & ~READ_DURING_I;
  wire master_during     = master & READ_DURING_I;
  wire in_conv           = (state_reg == S_CONV);
  wire eoc               = in_conv & (cnt_reg == conv_cyc - 8'h01);
  wire during_go         = in_conv & master_during & ~ser.active & ~frame_reg &
                           (cnt_reg == frame_cyc - 8'h01);
  wire slave_go          = eoc & SERIAL_MODE_I & ~SERIAL_MASTER_I;

  // after conversion the new result is sent; during conversion the previous one
  assign ser.load     = (eoc & (master_after | SERIAL_MODE_I & ~SERIAL_MASTER_I)) | during_go;
  assign ser.word     = during_go ? result_reg : RESULT_I;
  assign ser.start    = ser.load;
  assign ser.ext_mode = ~SERIAL_MASTER_I;
  assign ser.ext_clk  = SERIAL_CLK_I;
  assign ser.serial_data_in     = SERIAL_DATA_IN_I;
  assign ser.half     = (SERIAL_CLOCK_DIVIDER_I == 2'b00) ? SCLK_HALF_00 :
                        (SERIAL_CLOCK_DIVIDER_I == 2'b01) ? SCLK_HALF_01 :
                        (SERIAL_CLOCK_DIVIDER_I == 2'b10) ? SCLK_HALF_10 : SCLK_HALF_11;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 8'h01;
    busy_next  = busy_reg;
    frame_next = frame_reg & ~ser.done;
    if (during_go) begin
      frame_next = 1'b1;
    end
    case (state_reg)
      S_IDLE: begin
        cnt_next = 8'h00;
        if (start_fall) begin
          state_next = S_CONV;
          busy_next  = 1'b1;
        end
      end
      S_CONV: begin
        // start edges are not looked at outside idle
        if (eoc) begin
          cnt_next = 8'h00;
          if (master_after) begin
            state_next = S_XFER;
            frame_next = 1'b1;
          end else begin
            state_next = S_TAIL;
          end
        end
      end
      S_TAIL: begin
        if (cnt_reg == EOC_BUSY_CYC - 8'h01) begin
          state_next = S_IDLE;
          busy_next  = 1'b0;
        end
      end
      S_XFER: begin
        cnt_next = 8'h00;
        if (ser.done) begin
          state_next = S_FEND;
          frame_next = 1'b0;
        end
      end
      S_FEND: begin
        if (cnt_reg == FRAME_BUSY_CYC - 8'h01) begin
          state_next = S_IDLE;
          busy_next  = 1'b0;
        end
      end
      default: begin
        state_next = S_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rs1_reg <= 1'b0;
      rs2_reg <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rs2_reg <= rs1_reg;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 8'h00;
      busy_reg  <= 1'b0;
      frame_reg <= 1'b0;
      sprev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      frame_reg <= frame_next;
      sprev_reg <= CONVERSION_START_N_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 16'h0000;
    end else if (eoc) begin
      result_reg <= RESULT_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_n_reg <= 1'b1;
      ms_oe_n_reg   <= 1'b1;
      sdo_oe_n_reg  <= 1'b1;
    end else begin
      data_oe_n_reg <= CS_N_I | SERIAL_MODE_I;
      ms_oe_n_reg   <= CS_N_I | ~master;
      sdo_oe_n_reg  <= CS_N_I | ~SERIAL_MODE_I;
    end
  end

  assign BUSY_O                 = busy_reg;
  assign DATA_O                 = result_reg;
  assign DATA_OE_N_O            = data_oe_n_reg;
  assign FRAME_O                = frame_reg;
  assign FRAME_OE_N_O           = ms_oe_n_reg;
  assign SERIAL_CLK_O           = ser.sclk;
  assign SERIAL_CLK_OE_N_O      = ms_oe_n_reg;
  assign SERIAL_DATA_OUT_O      = ser.sdo;
  assign SERIAL_DATA_OUT_OE_N_O = sdo_oe_n_reg;
endmodule
`default_nettype wire

// *** acs_top_sva.sv ***
/*
  Timing checks on the converter control ports.
  Assumes it is bound to acs_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module acs_top_sva (
  input wire logic        CLOCK_I,
  input wire logic        NRST_I,
  input wire logic        FAST_MODE_I,
  input wire logic        LOW_POWER_MODE_I,
  input wire logic        SERIAL_MODE_I,
  input wire logic        SERIAL_MASTER_I,
  input wire logic        READ_DURING_I,
  input wire logic [1:0]  SERIAL_CLOCK_DIVIDER_I,
  input wire logic        CS_N_I,
  input wire logic        BUSY_O,
  input wire logic [15:0] DATA_O,
  input wire logic        DATA_OE_N_O,
  input wire logic        FRAME_O,
  input wire logic        FRAME_OE_N_O,
  input wire logic        SERIAL_CLK_OE_N_O,
  input wire logic        SERIAL_CLK_O,
  input wire logic        SERIAL_DATA_OUT_OE_N_O
);
  logic [7:0] busy_cnt_reg;
  logic [2:0] hi_cnt_reg;
  logic [1:0] live_reg;
  wire        after_w  = SERIAL_MODE_I && SERIAL_MASTER_I && !READ_DURING_I;
  wire        during_w = SERIAL_MODE_I && SERIAL_MASTER_I && READ_DURING_I;
  // busy limit in cycles per speed mode
  wire  [7:0] lim_w    = LOW_POWER_MODE_I ? 8'h32 : (FAST_MODE_I ? 8'h1e : 8'h28);
  wire  [2:0] half_w   = (SERIAL_CLOCK_DIVIDER_I == 2'h3) ? 3'h4 :
                         ((SERIAL_CLOCK_DIVIDER_I == 2'h2) ? 3'h2 : 3'h1);
  wire        ms_off_w  = CS_N_I || !SERIAL_MODE_I || !SERIAL_MASTER_I;
  wire        sdo_off_w = CS_N_I || !SERIAL_MODE_I;
  wire        par_off_w = CS_N_I || SERIAL_MODE_I;
  wire  [1:0] spd_w     = LOW_POWER_MODE_I ? 2'h2 : (FAST_MODE_I ? 2'h0 : 2'h1);
  logic [7:0] lim8_w;
  // busy limit in read after conversion, in cycles, per speed and divider
  always_comb begin
    case ({spd_w, SERIAL_CLOCK_DIVIDER_I})
      4'h0:    lim8_w = 8'h3c;
      4'h1:    lim8_w = 8'h50;
      4'h2:    lim8_w = 8'h78;
      4'h3:    lim8_w = 8'hd2;
      4'h4:    lim8_w = 8'h46;
      4'h5:    lim8_w = 8'h5a;
      4'h6:    lim8_w = 8'h82;
      4'h7:    lim8_w = 8'hde;
      4'h8:    lim8_w = 8'h50;
      4'h9:    lim8_w = 8'h64;
      4'ha:    lim8_w = 8'h8c;
      default: lim8_w = 8'he6;
    endcase
  end
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      busy_cnt_reg <= 8'h0;
      hi_cnt_reg <= 3'h0;
      live_reg <= 2'h0;
    end else begin
      busy_cnt_reg <= BUSY_O ? busy_cnt_reg + 8'h1 : 8'h0;
      hi_cnt_reg <= SERIAL_CLK_O ? hi_cnt_reg + 3'h1 : 3'h0;
      live_reg <= {live_reg[0], 1'b1};
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  a_busy_limit: assert property (
    BUSY_O && !after_w |-> busy_cnt_reg < lim_w)
    else $error("busy high too long");
  a_busy_serial: assert property (
    BUSY_O && after_w |-> busy_cnt_reg < lim8_w)
    else $error("busy too long in read after conversion");
  a_data_before_busy: assert property (
    $fell(BUSY_O) && !SERIAL_MODE_I |-> $stable(DATA_O))
    else $error("data changed as busy fell");
  a_data_in_busy: assert property (
    $changed(DATA_O) && !SERIAL_MODE_I |-> BUSY_O)
    else $error("busy fell with end of conversion");
  a_sclk_half: assert property (
    $fell(SERIAL_CLK_O) && after_w |-> hi_cnt_reg == half_w)
    else $error("serial clock high phase wrong");
  a_frame_after: assert property (
    $rose(BUSY_O) && after_w |-> ##[20:49] $rose(FRAME_O))
    else $error("frame late after conversion");
  a_frame_during: assert property (
    $rose(BUSY_O) && during_w && !FRAME_O |-> ##[0:21] $rose(FRAME_O))
    else $error("frame late during conversion");
  a_busy_after_frame: assert property (
    $fell(FRAME_O) && after_w |=> $fell(BUSY_O))
    else $error("busy did not follow frame");
  a_oe_frame_clk: assert property (
    live_reg[1] |=> {FRAME_OE_N_O, SERIAL_CLK_OE_N_O} == {2{$past(ms_off_w)}})
    else $error("frame or clock enable wrong");
  a_oe_sdo: assert property (
    live_reg[1] |=> SERIAL_DATA_OUT_OE_N_O == $past(sdo_off_w))
    else $error("serial data enable wrong");
  a_oe_data: assert property (
    live_reg[1] |=> DATA_OE_N_O == $past(par_off_w))
    else $error("parallel data enable wrong");
  c_after: cover property ($fell(FRAME_O) && after_w);
  c_during: cover property ($rose(FRAME_O) && during_w);
  c_parallel: cover property ($fell(BUSY_O) && !SERIAL_MODE_I);
endmodule
bind acs_top acs_top_sva u_acs_top_sva (.CLOCK_I, .NRST_I, .FAST_MODE_I, .LOW_POWER_MODE_I,
  .SERIAL_MODE_I, .SERIAL_MASTER_I, .READ_DURING_I, .SERIAL_CLOCK_DIVIDER_I, .CS_N_I,
  .BUSY_O, .DATA_O, .DATA_OE_N_O, .FRAME_O, .FRAME_OE_N_O, .SERIAL_CLK_OE_N_O, .SERIAL_CLK_O,
  .SERIAL_DATA_OUT_OE_N_O);
`default_nettype wire

// *** testbench.sv ***
/*
  Self-checking bench: conversions in parallel, master and slave serial modes.
  Assumes acs_top, its checker and the host reader model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 0, nrst = 0, st_n = 1, fast = 0, lowp = 0, ser = 0, mst = 0;
  logic        dur = 0, cs_n = 0, serial_data_in = 0, go = 0, busy_q = 0;
  logic [1:0]  div = 2'h0;
  logic [15:0] res = 16'h0, last = 16'h0;
  logic        busy, fr, sclk, sdo, ext, hv;
  logic [15:0] dat, hw;
  logic [15:0] exp_q[$];
  int          num_errors = 0, compares = 0, cyc = 0, seed = 32'heaf48071;
  always #12.5 clk = ~clk;
  acs_top u_acs_top (.CLOCK_I(clk), .NRST_I(nrst), .CONVERSION_START_N_I(st_n),
    .FAST_MODE_I(fast), .LOW_POWER_MODE_I(lowp), .SERIAL_MODE_I(ser), .SERIAL_MASTER_I(mst),
    .READ_DURING_I(dur), .SERIAL_CLOCK_DIVIDER_I(div), .CS_N_I(cs_n), .RESULT_I(res),
    .SERIAL_CLK_I(ext), .SERIAL_DATA_IN_I(serial_data_in), .BUSY_O(busy), .DATA_O(dat),
    .DATA_OE_N_O(), .FRAME_O(fr), .FRAME_OE_N_O(), .SERIAL_CLK_O(sclk),
    .SERIAL_CLK_OE_N_O(), .SERIAL_DATA_OUT_O(sdo), .SERIAL_DATA_OUT_OE_N_O());
  acs_host_model u_acs_host_model (.clk_i(clk), .frame_i(fr), .sclk_i(sclk), .sdo_i(sdo),
    .go_i(go), .ext_clk_o(ext), .word_o(hw), .valid_o(hv));
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one conversion; in master read after conversion, a second start while busy that must be ignored
  task automatic conv;
    int n;
    n = 0;
    @(negedge clk);
    res = 16'($random(seed));
    serial_data_in = 1'($random(seed));
    exp_q.push_back((ser && mst && dur) ? last : res);
    last = res;
    st_n = 0;
    @(negedge clk);
    st_n = 1;
    // only a read after conversion keeps busy past the least start spacing
    if (ser && mst && !dur) begin
      repeat (39) @(negedge clk);
      st_n = 0;
      @(negedge clk);
      st_n = 1;
    end
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    chk({15'h0, busy}, 16'h0);
    if (ser && !mst) go = 1;
    @(negedge clk);
    go = 0;
    repeat (200) @(negedge clk);
  endtask
  // results are compared against the oldest note
  // sampled on the falling edge, away from the edge that launches the outputs
  always @(negedge clk) begin
    busy_q <= busy;
    if (hv) chk(hw, exp_q.pop_front());
    if (busy_q && !busy && !ser) chk(dat, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1;
    repeat (4) @(negedge clk);
    for (int s = 0; s < 3; s++) begin
      fast = (s == 0);
      lowp = (s == 2);
      conv();
    end
    ser = 1;
    mst = 1;
    fast = 1;
    lowp = 0;
    for (int d = 0; d < 4; d++) begin
      div = 2'(d);
      conv();
    end
    dur = 1;
    div = 2'h0;
    for (int s = 0; s < 3; s++) begin
      fast = (s == 0);
      lowp = (s == 2);
      conv();
    end
    dur = 0;
    mst = 0;
    conv();
    conv();
    cs_n = 1;
    repeat (5) @(negedge clk);
    chk(16'(exp_q.size()), 16'h0);
    conclude();
  end
endmodule
`default_nettype wire
